// [hw/imm_byte_cell.sv]
`timescale 1ns/1ps
// ****************************************************************
// one byte of data memory held in flip-flops
// ****************************************************************
module imm_byte_cell #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic we,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] byte_r;

   // store the byte on a selected write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         byte_r <= '0;
      end else if (we) begin
         byte_r <= d;
      end
   end

   assign q = byte_r;

endmodule

// [hw/imm_data_mem.sv]
`timescale 1ns/1ps
// Summary of operation
// - 256 bytes of RAM, addresses 0x00-0xFF
// - lower 128 bytes: direct or indirect access
// - upper 128 bytes: indirect only, separate store
// - direct above 0x7F goes to special registers
// - indirect above 0x7F goes to upper RAM
// - four register banks, status bits 3,4 select
// - indirect address from index register 0/1
// - bytes 0x20-0x2F hold bits 0x00-0x7F
// - bit versus byte chosen by access type
// - push writes pointer+1, then pointer increments
// - reset loads stack pointer with 0x07
// - stack spans full 256-byte data memory
// - stack pointer is special register 0x81
// - special registers are direct 0x80-0xFF
// - bit access only to registers ending 0/8
module imm_data_mem
   import imm_pkg::*;
#(
   parameter int DEPTH = RAM_BYTES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic acc_valid,
   input wire logic acc_we,
   input wire imm_mode_t acc_mode,
   input wire logic acc_sel_one,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   input wire logic acc_wbit,
   input wire logic [7:0] program_status_word,
   output logic [7:0] rd_data_r,
   output logic rd_bit_r,
   output logic rd_valid_r,
   output logic [7:0] stack_top_pointer,
   output logic [7:0] sfr_addr,
   output logic sfr_rd,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata
);

   // ****************************************************************
   // storage
   // ****************************************************************
   logic [7:0] ram_q [DEPTH];
   logic [7:0] eff_addr;
   logic [7:0] wr_byte;
   logic ram_we;

   // one flip-flop byte per location, lower and upper halves alike
   for (genvar i = 0; i < DEPTH; i++) begin : g_ram
      imm_byte_cell #(
         .WIDTH(8)
      ) u_cell (
         .clk_sys(clk_sys),
         .rst(rst),
         .we(ram_we && (eff_addr == 8'(i))),
         .d(wr_byte),
         .q(ram_q[i])
      );
   end

   // ****************************************************************
   // working register and index pointer selection
   // ****************************************************************
   logic [1:0] bank_sel;
   logic [7:0] idx_loc;
   logic [7:0] idx_ptr;

   // active bank from status word bits 3 and 4
   assign bank_sel = {program_status_word[PSW_BANK_HI],
                      program_status_word[PSW_BANK_LO]};

   // index register 0 or 1 of the active bank: bank*8 + sel
   assign idx_loc = {3'b000, bank_sel, 2'b00, acc_sel_one};
   assign idx_ptr = ram_q[idx_loc];

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic [7:0] sp_r;
   logic [7:0] sp_nxt;
   logic [2:0] bit_pos;
   logic to_ram;
   logic to_sp;
   logic to_sfr;
   logic is_bit;

   // steer each access by its kind, and direct and bit accesses also by the address value
   always_comb begin
      eff_addr = acc_addr;
      bit_pos = acc_addr[2:0];
      to_ram = 1'b0;
      to_sp = 1'b0;
      to_sfr = 1'b0;
      is_bit = 1'b0;
      case (acc_mode)
         IMM_DIRECT: begin
            eff_addr = acc_addr;
            if (acc_addr > LOWER_TOP) begin
               // upper direct space is the register file
               to_sp = (acc_addr == SP_ADDR);
               to_sfr = (acc_addr != SP_ADDR);
            end else begin
               to_ram = 1'b1;
            end
         end
         IMM_INDIRECT: begin
            eff_addr = idx_ptr;
            to_ram = 1'b1;
         end
         IMM_BIT: begin
            is_bit = 1'b1;
            if (acc_addr > LOWER_TOP) begin
               // register address is the upper five bits
               eff_addr = {acc_addr[7:3], 3'b000};
               to_sp = 1'b0;
               to_sfr = 1'b1;
            end else begin
               // byte 0x20 plus bit address divided by eight
               eff_addr = {BIT_BYTE_HI, acc_addr[6:3]};
               to_ram = 1'b1;
            end
         end
         IMM_PUSH: begin
            eff_addr = sp_r + SP_STEP;
            to_ram = 1'b1;
         end
         IMM_POP: begin
            eff_addr = sp_r;
            to_ram = 1'b1;
         end
         default: begin
            eff_addr = acc_addr;
         end
      endcase
   end

   // ****************************************************************
   // read value and write merge
   // ****************************************************************
   logic [7:0] rd_byte;
   logic acc_wr;

   // a push always writes, a pop always reads
   assign acc_wr = (acc_mode == IMM_PUSH) ||
                   (acc_we && (acc_mode != IMM_POP));

   // byte seen by the access before any write
   always_comb begin
      if (to_ram) begin
         rd_byte = ram_q[eff_addr];
      end else if (to_sp) begin
         rd_byte = sp_r;
      end else begin
         rd_byte = sfr_rdata;
      end
   end

   // a bit write replaces one bit of the byte it lives in
   always_comb begin
      wr_byte = acc_wdata;
      if (is_bit) begin
         wr_byte = rd_byte;
         wr_byte[bit_pos] = acc_wbit;
      end
   end

   assign ram_we = acc_valid && acc_wr && to_ram;

   // ****************************************************************
   // special register space port
   // ****************************************************************
   // direct upper addresses other than 0x81, and high bit addresses, leave the block
   assign sfr_addr = eff_addr;
   assign sfr_rd = acc_valid && to_sfr;
   assign sfr_wr = acc_valid && to_sfr && acc_wr;
   assign sfr_wdata = wr_byte;

   // ****************************************************************
   // stack pointer
   // ****************************************************************
   // push increments, pop decrements, direct write loads
   always_comb begin
      sp_nxt = sp_r;
      if (acc_valid) begin
         if (acc_mode == IMM_PUSH) begin
            sp_nxt = sp_r + SP_STEP;
         end else if (acc_mode == IMM_POP) begin
            sp_nxt = sp_r - SP_STEP;
         end else if (to_sp && acc_wr) begin
            sp_nxt = wr_byte;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sp_r <= SP_RESET;
      end else begin
         sp_r <= sp_nxt;
      end
   end

   assign stack_top_pointer = sp_r;

   // ****************************************************************
   // read return
   // ****************************************************************
   // read data one cycle after a read access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= 8'h00;
         rd_bit_r <= 1'b0;
      end else begin
         rd_valid_r <= acc_valid && !acc_wr;
         if (acc_valid && !acc_wr) begin
            rd_data_r <= rd_byte;
            rd_bit_r <= rd_byte[bit_pos];
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic push_go;
   logic pop_go;
   assign push_go = acc_valid && (acc_mode == IMM_PUSH);
   assign pop_go = acc_valid && (acc_mode == IMM_POP);

   chk_sp_reset: assert property (
      $fell(rst) |-> sp_r == SP_RESET)
      else $error("stack pointer not 0x07 after reset");

   chk_push_ptr: assert property (
      push_go |=> sp_r == $past(sp_r) + SP_STEP)
      else $error("push did not increment pointer");

   chk_push_data: assert property (
      push_go |=> ram_q[sp_r] == $past(acc_wdata))
      else $error("push data not at new pointer");

   chk_pop_ptr: assert property (
      pop_go |=> sp_r == $past(sp_r) - SP_STEP
                 && rd_data_r == ram_q[$past(sp_r)])
      else $error("pop pointer or data wrong");

   chk_dir_upper: assert property (
      acc_valid && acc_mode == IMM_DIRECT && acc_addr[7]
      && acc_addr != SP_ADDR |-> sfr_rd && !ram_we)
      else $error("direct upper access reached RAM");

   chk_ind_upper: assert property (
      acc_valid && acc_mode == IMM_INDIRECT |-> !sfr_rd && !sfr_wr
      && to_ram && ram_we == acc_we)
      else $error("indirect access wrong route");

   chk_ind_write: assert property (
      acc_valid && acc_we && acc_mode == IMM_INDIRECT
      |=> ram_q[$past(eff_addr)] == $past(acc_wdata))
      else $error("indirect write lost");

   chk_bank_index: assert property (
      idx_loc <= BANK_TOP && idx_loc[2:1] == 2'b00
      && idx_loc[4:3] == program_status_word[4:3])
      else $error("index register outside active bank");

   chk_bit_byte: assert property (
      acc_valid && acc_mode == IMM_BIT && !acc_addr[7]
      |-> eff_addr >= BIT_BASE && eff_addr <= BIT_LAST)
      else $error("bit address outside bit bytes");

   chk_bit_write: assert property (
      acc_valid && acc_we && acc_mode == IMM_BIT && !acc_addr[7]
      |=> ram_q[$past(eff_addr)][$past(bit_pos)] == $past(acc_wbit)
          && ((ram_q[$past(eff_addr)] ^ $past(rd_byte))
              & ~(8'h01 << $past(bit_pos)))
             == 8'h00)
      else $error("bit write disturbed other bits");

   chk_sfr_bitaddr: assert property (
      sfr_rd && acc_mode == IMM_BIT |-> sfr_addr[2:0] == 3'b000
      && sfr_addr[7:3] == acc_addr[7:3])
      else $error("bit access to unaligned register");

   chk_sp_direct: assert property (
      acc_valid && acc_we && acc_mode == IMM_DIRECT
      && acc_addr == SP_ADDR |-> !sfr_wr ##1 sp_r == $past(acc_wdata))
      else $error("direct write to 0x81 missed pointer");

   cov_push: cover property (push_go ##1 push_go);
   cov_pop: cover property (push_go ##1 pop_go);
   cov_ind_upper: cover property (
      acc_valid && acc_mode == IMM_INDIRECT && eff_addr[7]);
   cov_sfr_bit: cover property (sfr_wr && acc_mode == IMM_BIT);

endmodule

// [hw/imm_pkg.sv]
package imm_pkg;

   // ****************************************************************
   // memory map
   // ****************************************************************
   localparam int RAM_BYTES = 256;
   localparam logic [7:0] LOWER_TOP = 8'h7F;
   localparam logic [7:0] BANK_TOP = 8'h1F;
   localparam logic [3:0] BIT_BYTE_HI = 4'h2; // bit bytes 0x20..0x2F
   localparam logic [7:0] BIT_BASE = 8'h20;
   localparam logic [7:0] BIT_LAST = 8'h2F;
   localparam logic [7:0] SFR_BASE = 8'h80;

   // ****************************************************************
   // stack pointer register
   // ****************************************************************
   localparam logic [7:0] SP_ADDR = 8'h81;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] SP_STEP = 8'h01;

   // ****************************************************************
   // status word fields
   // ****************************************************************
   localparam int PSW_BANK_LO = 3;
   localparam int PSW_BANK_HI = 4;

   // ****************************************************************
   // access kinds presented by the core
   // ****************************************************************
   typedef enum logic [2:0] {
      IMM_DIRECT = 3'h0,
      IMM_INDIRECT = 3'h1,
      IMM_BIT = 3'h2,
      IMM_PUSH = 3'h3,
      IMM_POP = 3'h4
   } imm_mode_t;

endpackage

// [tb/imm_sfr_model.sv]
`timescale 1ns/1ps
// *****
// special register file seen through the forwarded strobes
// *****
module imm_sfr_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_rd,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata
);
   logic [7:0] regs_r [256];
   logic [7:0] junk_r;

   // registers reset to the inverse of their address, junk runs freely
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 256; i++) begin
            regs_r[i] <= ~i[7:0];
         end
         junk_r <= 8'h5a;
      end else begin
         junk_r <= junk_r + 8'h3b;
         if (sfr_wr) begin
            regs_r[sfr_addr] <= sfr_wdata;
         end
      end
   end

   // read data only while selected; otherwise a changing pattern
   assign sfr_rdata = sfr_rd ? regs_r[sfr_addr] : junk_r;
endmodule

// [tb/internal_data_memory_map_tb.sv]
`timescale 1ns/1ps
module internal_data_memory_map_tb;
   import imm_pkg::*;
   logic clk_sys = 0;
   logic rst = 1;
   logic acc_valid = 0;
   logic acc_we = 0;
   logic acc_sel_one = 0;
   logic acc_wbit = 0;
   imm_mode_t acc_mode = IMM_DIRECT;
   logic [7:0] acc_addr = 8'h00;
   logic [7:0] acc_wdata = 8'h00;
   logic [7:0] program_status_word = 8'h00;
   logic [7:0] rd_data_r, stack_top_pointer, sfr_addr, sfr_wdata;
   logic [7:0] sfr_rdata, rnd;
   logic rd_bit_r, rd_valid_r, sfr_rd, sfr_wr;
   logic [8:0] exp_q [$];
   logic [8:0] e;
   logic [7:0] vals [3];
   int miscompares = 0;
   int samples_checked = 0;

   // *****
   // clock, design and far side
   // *****
   always #10 clk_sys = ~clk_sys;

   imm_data_mem DUT (.clk_sys, .rst, .acc_valid, .acc_we, .acc_mode,
      .acc_sel_one, .acc_addr, .acc_wdata, .acc_wbit, .program_status_word,
      .rd_data_r, .rd_bit_r, .rd_valid_r, .stack_top_pointer, .sfr_addr,
      .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata);

   imm_sfr_model sfr (.clk_sys, .rst, .sfr_addr, .sfr_rd, .sfr_wr,
      .sfr_wdata, .sfr_rdata);

   // *****
   // helpers
   // *****
   function automatic logic [7:0] xs(input logic [7:0] x);
      logic [7:0] y;
      y = x ^ (x << 3);
      y = y ^ (y >> 5);
      return y ^ (y << 1);
   endfunction

   task automatic check(input string what, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one access, presented just after an edge and taken at the next
   task automatic acc(input imm_mode_t m, input logic we, sel,
                      input logic [7:0] a, d, input logic b);
      @(posedge clk_sys);
      #1;
      acc_valid = 1;
      acc_mode = m;
      acc_we = we;
      acc_sel_one = sel;
      acc_addr = a;
      acc_wdata = d;
      acc_wbit = b;
   endtask

   // read access with its expected result noted; bit 8 marks a bit read
   task automatic rd(input imm_mode_t m, input logic sel,
                     input logic [7:0] a, input logic [8:0] x);
      acc(m, 1'b0, sel, a, 8'h00, 1'b0);
      exp_q.push_back(x);
   endtask

   task automatic idle;
      @(posedge clk_sys);
      #1;
      acc_valid = 0;
   endtask

   // wait a bounded time for the noted reads to come back
   task automatic drain;
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_sys);
      if (exp_q.size() > 0) check("pending reads", 8'h00, 8'h01);
   endtask

   // *****
   // result monitor: oldest note against each read pulse
   // *****
   always @(negedge clk_sys) begin
      if (rd_valid_r === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected read", 8'h00, 8'h01);
         end else begin
            e = exp_q.pop_front();
            if (e[8]) check("read bit", {7'h00, rd_bit_r}, e[7:0]);
            else check("read byte", rd_data_r, e[7:0]);
         end
      end
   end

   // watchdog against a hang
   initial begin
      #200000;
      check("timeout", 8'h00, 8'h01);
      conclude();
   end

   // *****
   // main sequence
   // *****
   initial begin
      rnd = 8'h62;
      repeat (4) @(posedge clk_sys);
      #1 rst = 0;
      // pointer after reset, first push lands at bank one
      rd(IMM_DIRECT, 0, SP_ADDR, {1'b0, SP_RESET});
      acc(IMM_PUSH, 1, 0, 8'h00, 8'h5A, 0);
      rd(IMM_DIRECT, 0, 8'h08, 9'h05A);
      rd(IMM_DIRECT, 0, SP_ADDR, 9'h008);
      idle();
      check("pointer", stack_top_pointer, 8'h08);
      // bank two index registers steer indirect accesses
      program_status_word = 8'h10;
      acc(IMM_DIRECT, 1, 0, 8'h10, 8'h98, 0);
      acc(IMM_DIRECT, 1, 0, 8'h11, 8'h30, 0);
      acc(IMM_INDIRECT, 1, 0, 8'h00, 8'hC3, 0);
      acc(IMM_INDIRECT, 1, 1, 8'h00, 8'h3C, 0);
      rd(IMM_INDIRECT, 0, 8'h00, 9'h0C3);
      rd(IMM_DIRECT, 0, 8'h30, 9'h03C);
      rd(IMM_DIRECT, 0, 8'h98, 9'h067);
      // bit region and bit-addressable special register
      acc(IMM_BIT, 1, 0, 8'h13, 8'h00, 1);
      rd(IMM_BIT, 0, 8'h13, 9'h101);
      rd(IMM_DIRECT, 0, 8'h22, 9'h008);
      acc(IMM_BIT, 1, 0, 8'h83, 8'h00, 0);
      rd(IMM_DIRECT, 0, 8'h80, 9'h077);
      rd(IMM_BIT, 0, 8'h84, 9'h101);
      // stack near the top of memory, wrapping past 0xFF
      acc(IMM_DIRECT, 1, 0, SP_ADDR, 8'hFD, 0);
      for (int i = 0; i < 3; i++) begin
         rnd = xs(rnd);
         vals[i] = rnd;
         acc(IMM_PUSH, 1, 0, 8'h00, rnd, 0);
      end
      for (int i = 2; i >= 0; i--) begin
         rd(IMM_POP, 0, 8'h00, {1'b0, vals[i]});
      end
      rd(IMM_DIRECT, 0, SP_ADDR, 9'h0FD);
      idle();
      drain();
      // mid-run reset reloads the pointer and clears the memory
      #1 rst = 1;
      repeat (2) @(posedge clk_sys);
      #1 rst = 0;
      rd(IMM_DIRECT, 0, SP_ADDR, {1'b0, SP_RESET});
      rd(IMM_DIRECT, 0, 8'h08, 9'h000);
      idle();
      drain();
      conclude();
   end
endmodule
